// ==== pkg/rxbal_pkg.sv ====
// rxbal_pkg: constants and carriers for the receive buffer address table loader.
// assumes a single clock domain and CSR writes issued from logic on that clock.
package rxbal_pkg;

	// csr indices on the write port
	localparam logic [7:0]  RXBAL_CSR_SLOT_SELECT = 8'h06;
	localparam logic [7:0]  RXBAL_CSR_RESERVED    = 8'h07;
	localparam logic [7:0]  RXBAL_CSR_LOW_DWORD   = 8'h08;
	localparam logic [7:0]  RXBAL_CSR_HIGH_DWORD  = 8'h09;

	// widths and table shape
	localparam int          RXBAL_SLOT_W    = 6;
	localparam int          RXBAL_SLOTS     = 64;
	localparam int          RXBAL_DWORD_W   = 32;
	localparam int          RXBAL_ADDR_W    = 64;
	localparam int          RXBAL_SLOT_LSB  = 0;
	localparam int          RXBAL_LOW_LSB   = 0;
	localparam int          RXBAL_HIGH_LSB  = 32;

	// reset values
	localparam logic [5:0]  RXBAL_SLOT_RST  = 6'h00;
	localparam logic [31:0] RXBAL_HIGH_RST  = 32'h0000_0000;

	// one csr write: wide marks a 64-bit access
	typedef struct packed {
		logic        en;
		logic        wide;
		logic [7:0]  idx;
		logic [63:0] data;
	} rxbal_csr_wr_t;

	// table lookup answer
	typedef struct packed {
		logic        valid;
		logic [63:0] addr;
	} rxbal_lookup_t;

	// all state of the loader
	typedef struct packed {
		logic [5:0]  slot;
		logic [31:0] upper;
		logic        lu_valid;
	} rxbal_state_t;

endpackage

// ==== hdl/rxbal_table.sv ====
// rxbal_table: on-chip storage of buffer physical addresses, one write and one read port.
// assumes the loader drives the write port; read data appears one clock after the request.
`timescale 1ns/1ps
module rxbal_table
	import rxbal_pkg::*;
#(
	parameter int SLOTS  = RXBAL_SLOTS,
	parameter int ADDR_W = RXBAL_ADDR_W,
	parameter int IDX_W  = RXBAL_SLOT_W
) (
	// clock
	input  wire logic              clk_i,
	// write port
	input  wire logic              we_i,
	input  wire logic [IDX_W-1:0]  wr_idx_i,
	input  wire logic [ADDR_W-1:0] wr_data_i,
	// read port
	input  wire logic [IDX_W-1:0]  rd_idx_i,
	output logic      [ADDR_W-1:0] rd_data_o
);

	// no reset on the array: entries are undefined until software loads them
	logic [ADDR_W-1:0] mem [SLOTS];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[wr_idx_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_idx_i];
	end

	AST_TBL_WRITE: assert property (@(posedge clk_i)
		we_i |=> mem[$past(wr_idx_i)] == $past(wr_data_i))
		else $error("table entry not written as presented");

endmodule // rxbal_table

// ==== hdl/rxbal_loader.sv ====
// rxbal_loader: receive buffer address table loader with csr write port and lookup port.
// assumes csr writes and lookups come from logic on clk_i; one access per cycle at most.
`timescale 1ns/1ps

// Contract
// - slot index picks slot for low write
// - table holds exactly 64 entries
// - table lives in on-chip storage
// - buffer identifier looks up destination address
// - 64-bit write to the lower dword loads both dwords at once; a 64-bit upper write takes only data[31:0]
// - upper dword retained across narrow lower writes
// - lower write commits upper plus lower
// - lower dword stored in selected slot
// - upper write only updates holding register
module rxbal_loader
	import rxbal_pkg::*;
(
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// csr write port
	input  wire rxbal_csr_wr_t csr_wr_i,
	// receive command lookup
	input  wire logic          lookup_req_i,
	input  wire logic [5:0]    buffer_identifier_i,
	output rxbal_lookup_t      lookup_o
);

	rxbal_state_t st;
	rxbal_state_t next_st;

	logic                    hit_slot;
	logic                    hit_low;
	logic                    hit_high;
	logic                    tbl_we;
	logic [RXBAL_SLOT_W-1:0] tbl_idx;
	logic [RXBAL_ADDR_W-1:0] tbl_data;
	logic [RXBAL_ADDR_W-1:0] rd_data;

	function automatic logic csr_hit(input rxbal_csr_wr_t w, input logic [7:0] idx);
		csr_hit = w.en && (w.idx == idx);
	endfunction

	// reserved index falls through every decode, so writes there are dropped
	assign hit_slot = csr_hit(csr_wr_i, RXBAL_CSR_SLOT_SELECT);
	assign hit_low  = csr_hit(csr_wr_i, RXBAL_CSR_LOW_DWORD);
	assign hit_high = csr_hit(csr_wr_i, RXBAL_CSR_HIGH_DWORD);

	assign tbl_we  = hit_low;
	assign tbl_idx = st.slot;

	// wide takes both dwords, narrow takes held upper
	always_comb begin
		tbl_data = {st.upper, csr_wr_i.data[RXBAL_LOW_LSB +: RXBAL_DWORD_W]};
		if (csr_wr_i.wide) begin
			tbl_data = csr_wr_i.data;
		end
	end

	always_comb begin
		next_st          = st;
		next_st.lu_valid = lookup_req_i;
		// slot changes only on its own write
		if (hit_slot) begin
			next_st.slot = csr_wr_i.data[RXBAL_SLOT_LSB +: RXBAL_SLOT_W];
		end
		// upper write touches holding register only
		if (hit_high) begin
			next_st.upper = csr_wr_i.data[RXBAL_LOW_LSB +: RXBAL_DWORD_W];
		end
		// wide low write refreshes held upper, narrow keeps it
		if (hit_low && csr_wr_i.wide) begin
			next_st.upper = csr_wr_i.data[RXBAL_HIGH_LSB +: RXBAL_DWORD_W];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st.slot     <= RXBAL_SLOT_RST;
			st.upper    <= RXBAL_HIGH_RST;
			st.lu_valid <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// entries carry no reset, so unloaded slots read back unknown
	// 64-slot on-chip array
	rxbal_table #(
		.SLOTS  (RXBAL_SLOTS),
		.ADDR_W (RXBAL_ADDR_W),
		.IDX_W  (RXBAL_SLOT_W)
	) u_table (
		.clk_i     (clk_i),
		.we_i      (tbl_we),
		.wr_idx_i  (tbl_idx),
		.wr_data_i (tbl_data),
		.rd_idx_i  (buffer_identifier_i),
		.rd_data_o (rd_data)
	);

	// valid and addr both leave flops, so they stay aligned
	// answer one cycle after request
	assign lookup_o.valid = st.lu_valid;
	assign lookup_o.addr  = rd_data;

	AST_SLOT_PICK: assert property (@(posedge clk_i) disable iff (rst_i)
		(hit_low && !csr_wr_i.wide)
		|=> u_table.mem[$past(st.slot)] == {$past(st.upper), $past(csr_wr_i.data[31:0])})
		else $error("lower write not routed to selected slot");

	AST_LOW_STORED: assert property (@(posedge clk_i) disable iff (rst_i)
		hit_low |-> tbl_data[31:0] == csr_wr_i.data[31:0])
		else $error("lower dword altered on commit");

	AST_COMMIT_PAIR: assert property (@(posedge clk_i) disable iff (rst_i)
		(hit_low && !csr_wr_i.wide) |-> tbl_data[63:32] == st.upper)
		else $error("commit does not use held upper dword");

	AST_HIGH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		hit_high |-> (!tbl_we ##1 st.upper == $past(csr_wr_i.data[31:0])))
		else $error("upper write misbehaved");

	// upper retained across narrow lower writes
	AST_HIGH_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
		(hit_low && !csr_wr_i.wide) |=> $stable(st.upper))
		else $error("held upper dword changed on lower write");

	AST_WIDE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(hit_low && csr_wr_i.wide) |-> (tbl_data == csr_wr_i.data
			##1 st.upper == $past(csr_wr_i.data[63:32])))
		else $error("wide write not committed whole");

	AST_NO_INCR: assert property (@(posedge clk_i) disable iff (rst_i)
		(tbl_we && !hit_slot) |=> st.slot == $past(st.slot))
		else $error("slot index moved after commit");

	AST_SLOT_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
		hit_slot |=> st.slot == $past(csr_wr_i.data[5:0]))
		else $error("slot index not loaded");

	AST_LOOKUP_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
		lookup_req_i |=> lookup_o.valid)
		else $error("lookup not answered in one cycle");

	AST_LOOKUP_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
		(tbl_we ##1 !tbl_we ##1 (lookup_req_i && !tbl_we && buffer_identifier_i == $past(tbl_idx, 2)))
		|=> lookup_o.addr == $past(tbl_data, 3))
		else $error("lookup returned wrong address");

	// slot index back at reset value
	AST_RST_SLOT: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> st.slot == RXBAL_SLOT_RST)
		else $error("slot index not at reset value");

	// held upper back at reset value
	AST_RST_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> st.upper == RXBAL_HIGH_RST)
		else $error("held upper dword not at reset value");

	AST_RST_VALID: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> !lookup_o.valid)
		else $error("lookup valid set out of reset");

	AST_RSVD_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
		(csr_wr_i.en && csr_wr_i.idx == RXBAL_CSR_RESERVED)
		|-> (!tbl_we ##1 ($stable(st.slot) && $stable(st.upper))))
		else $error("reserved write changed state");

	AST_UNKNOWN_IDX: assert property (@(posedge clk_i) disable iff (rst_i)
		(csr_wr_i.en && (csr_wr_i.idx < RXBAL_CSR_SLOT_SELECT || csr_wr_i.idx > RXBAL_CSR_HIGH_DWORD))
		|-> (!tbl_we ##1 ($stable(st.slot) && $stable(st.upper))))
		else $error("unknown index changed state");

	// table written only by lower write
	AST_WE_ONLY_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		tbl_we |-> (csr_wr_i.en && csr_wr_i.idx == RXBAL_CSR_LOW_DWORD))
		else $error("table written without lower write");

	// slot moves only on its write
	AST_SLOT_STEADY: assert property (@(posedge clk_i) disable iff (rst_i)
		!(csr_wr_i.en && csr_wr_i.idx == RXBAL_CSR_SLOT_SELECT) |=> $stable(st.slot))
		else $error("slot index moved without slot write");

	// upper moves only on its writes
	AST_UPPER_STEADY: assert property (@(posedge clk_i) disable iff (rst_i)
		!(csr_wr_i.en && (csr_wr_i.idx == RXBAL_CSR_HIGH_DWORD
			|| (csr_wr_i.idx == RXBAL_CSR_LOW_DWORD && csr_wr_i.wide))) |=> $stable(st.upper))
		else $error("held upper dword moved without upper write");

	AST_VALID_ONLY_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		!lookup_req_i |=> !lookup_o.valid)
		else $error("lookup valid without request");

	AST_WIDE_STORE: assert property (@(posedge clk_i) disable iff (rst_i)
		(hit_low && csr_wr_i.wide) |=> u_table.mem[$past(st.slot)] == $past(csr_wr_i.data))
		else $error("wide write not stored whole");

	AST_HIGH_WIDE: assert property (@(posedge clk_i) disable iff (rst_i)
		(hit_high && csr_wr_i.wide) |=> st.upper == $past(csr_wr_i.data[31:0]))
		else $error("wide upper write not taken as narrow");

endmodule // rxbal_loader

// ==== test/rxbal_host.sv ====
// rxbal_host: host model issuing csr writes to the loader.
// assumes callers enter its tasks at a rising edge.
`timescale 1ns/1ps
module rxbal_host
	import rxbal_pkg::*;
(
	// clock
	input  wire logic    clk_i,
	// csr write port
	output rxbal_csr_wr_t csr_wr_o
);
	initial csr_wr_o = '0;
	task automatic wr(input logic [7:0] i, input logic [63:0] d, input logic w);
		csr_wr_o <= '{en: 1'b1, wide: w, idx: i, data: d};
		@(posedge clk_i);
	endtask
	task automatic idle();
		csr_wr_o <= '0;
		@(posedge clk_i);
	endtask
	// load before use; narrow upper bits are junk
	task automatic load(input logic [5:0] s, input logic [31:0] h, input logic [31:0] l);
		wr(RXBAL_CSR_SLOT_SELECT, {58'h0, s}, 1'b0);
		wr(RXBAL_CSR_HIGH_DWORD, {~h, h}, 1'b0);
		wr(RXBAL_CSR_LOW_DWORD, {h, l}, 1'b0);
		idle();
	endtask
endmodule // rxbal_host

// ==== test/tb_top.sv ====
// tb_top: self-checking bench for the table loader.
// assumes lookup answers one clock after the request edge.
`timescale 1ns/1ps
module tb_top
	import rxbal_pkg::*;
;
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	rxbal_csr_wr_t csr_wr;
	logic          req = 1'b0;
	logic [5:0]    buffer_identifier = 6'h00;
	rxbal_lookup_t lookup_o;
	int            n_errors = 0;
	int            checked = 0;
	always #4 clk_i = ~clk_i;
	rxbal_host HOST (.clk_i(clk_i), .csr_wr_o(csr_wr));
	rxbal_loader DUT (.clk_i(clk_i), .rst_i(rst_i), .csr_wr_i(csr_wr),
		.lookup_req_i(req), .buffer_identifier_i(buffer_identifier), .lookup_o(lookup_o));
	task automatic tally_and_finish();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic look(input logic [5:0] s, input logic [63:0] exp);
		req <= 1'b1;
		buffer_identifier <= s;
		@(posedge clk_i);
		req <= 1'b0;
		#1;
		chk({63'h0, lookup_o.valid}, 64'h1);
		chk(lookup_o.addr, exp);
		@(posedge clk_i);
		#1;
		chk({63'h0, lookup_o.valid}, 64'h0);
		@(posedge clk_i);
	endtask
	task automatic sc_reset();
		HOST.wr(RXBAL_CSR_SLOT_SELECT, 64'h2, 1'b0);
		HOST.wr(RXBAL_CSR_LOW_DWORD, 64'hFFFF_FFFF_0000_00AA, 1'b0);
		HOST.idle();
		look(6'h02, 64'h0000_0000_0000_00AA);
	endtask
	task automatic sc_narrow();
		HOST.load(6'h05, 32'h89AB_CDEF, 32'h0123_4567);
		look(6'h05, 64'h89AB_CDEF_0123_4567);
	endtask
	task automatic sc_upper_kept();
		HOST.wr(RXBAL_CSR_SLOT_SELECT, 64'h3F, 1'b0);
		HOST.wr(RXBAL_CSR_LOW_DWORD, 64'hFFFF_FFFF_0000_1000, 1'b0);
		HOST.wr(RXBAL_CSR_LOW_DWORD, 64'h0000_0000_0000_2000, 1'b0);
		HOST.idle();
		look(6'h3F, 64'h89AB_CDEF_0000_2000);
		look(6'h05, 64'h89AB_CDEF_0123_4567);
	endtask
	task automatic sc_upper_hold();
		HOST.wr(RXBAL_CSR_HIGH_DWORD, 64'h5555_0000, 1'b0);
		HOST.wr(RXBAL_CSR_RESERVED, 64'h1, 1'b0);
		HOST.wr(8'h0A, 64'h2, 1'b0);
		HOST.idle();
		look(6'h3F, 64'h89AB_CDEF_0000_2000);
		HOST.wr(RXBAL_CSR_LOW_DWORD, 64'h7, 1'b0);
		HOST.idle();
		look(6'h3F, 64'h5555_0000_0000_0007);
	endtask
	task automatic sc_wide();
		HOST.wr(RXBAL_CSR_SLOT_SELECT, 64'h0, 1'b0);
		HOST.wr(RXBAL_CSR_LOW_DWORD, 64'hFEDC_BA98_7654_3210, 1'b1);
		HOST.wr(RXBAL_CSR_SLOT_SELECT, 64'h1, 1'b0);
		HOST.wr(RXBAL_CSR_LOW_DWORD, 64'h11, 1'b0);
		HOST.idle();
		look(6'h00, 64'hFEDC_BA98_7654_3210);
		look(6'h01, 64'hFEDC_BA98_0000_0011);
	endtask
	task automatic sc_mid_reset();
		rst_i <= 1'b1;
		req   <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk({63'h0, lookup_o.valid}, 64'h0);
		@(posedge clk_i);
		req   <= 1'b0;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		HOST.wr(RXBAL_CSR_LOW_DWORD, 64'h9, 1'b0);
		HOST.idle();
		look(6'h00, 64'h0000_0000_0000_0009);
		HOST.wr(RXBAL_CSR_HIGH_DWORD, 64'hAAAA_BBBB_1234_5678, 1'b1);
		HOST.wr(RXBAL_CSR_LOW_DWORD, 64'hA, 1'b0);
		HOST.idle();
		look(6'h00, 64'h1234_5678_0000_000A);
	endtask
	initial begin
		#100000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		sc_reset();
		sc_narrow();
		sc_upper_kept();
		sc_upper_hold();
		sc_wide();
		sc_mid_reset();
		tally_and_finish();
	end
endmodule // tb_top
